// ==== hdl/rec_trig_consts.svh ====
`ifndef REC_TRIG_CONSTS_SVH
`define REC_TRIG_CONSTS_SVH
// Register offsets (word addresses on the plain port)
`define OFF_CTRL        8'h00
`define OFF_SRC         8'h01
`define OFF_LEVEL       8'h02
`define OFF_TIME_LO     8'h03
`define OFF_TIME_HI     8'h04
`define OFF_CMD         8'h05
`define OFF_FREE        8'h06
`define OFF_BLOCKS      8'h07
`define OFF_STATE       8'h08
`define OFF_RD_COUNT    8'h09
// Control field positions
`define CTRL_REC_EN_BIT 0
`define CTRL_SLOPE_BIT  1
`define CTRL_SWEEP_BIT  2
// Command bits
`define CMD_BUS_TRG_BIT 0
`define CMD_DEL_ALL_BIT 1
`define CMD_READ_BIT    2
// Status weights
`define ST_UNDER        8'h01
`define ST_OVER         8'h02
`define ST_UNDEF        8'h08
`define ST_NAVAIL       8'h10
`define ST_PF_CAP       8'h80
`define ST_USED_MASK    8'h9b
// Reset values, fixed block count and NaN word
`define RST_SRC         3'h2
`define RST_LEVEL       32'h00000000
`define BLOCK_COUNT     32'h00000001
`define NAN_WORD        32'h7fc00000
`endif

// ==== hdl/rec_trig_pkg.sv ====
package rec_trig_pkg;
  // Start trigger sources
  typedef enum logic [2:0] {
    SRC_BUS   = 3'h0,
    SRC_TIME  = 3'h1,
    SRC_START_AT_ONCE = 3'h2,
    SRC_MANUAL = 3'h3,
    SRC_SYNC  = 3'h4,
    SRC_FUNC  = 3'h5
  } start_src_t;
  // Readout phases, one-hot
  typedef enum logic [3:0] {
    RD_IDLE   = 4'b0001,
    RD_DATA   = 4'b0010,
    RD_STATUS = 4'b0100,
    RD_DONE   = 4'b1000
  } rd_state_t;
endpackage

// ==== hdl/rec_mem.sv ====
`timescale 1ns/1ps
`include "rec_trig_consts.svh"
// Record store: value plus encoded status byte per entry
module rec_mem
  import rec_trig_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clock,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [39:0]   wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [39:0]   rd_data
);
  logic [39:0] mem [0:DEPTH-1];

  // Synchronous write, registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== hdl/rec_trig.sv ====
// Functional notes
// - Readout sends all values, then statuses
// - One status word per returned value
// - Status is OR of independent condition bits
// - Zero status means valid, nothing questionable
// - Weight 1 flags underrange, reduced precision
// - Weight 2 flags overrange, clipped samples
// - Weight 8 flags undefined, value NaN
// - Weight 16 flags unavailable, value NaN
// - Weight 128 flags capacitive power factor
// - Free bytes reported, restored by delete-all
// - Block count always reads one
// - No readout response until data exist
// - Triggers ignored unless recording enabled
// - Bus source starts on trigger command
// - Time source starts at programmed time
// - Start_at_once source starts at once
// - Manual source starts on record key
// - Sync edges trigger, realtime sweep only
// - Function source triggers on measurement condition
// - Function compared to level with chosen slope
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "rec_trig_consts.svh"
module rec_trig
  import rec_trig_pkg::*;
#(
  parameter int DEPTH       = 256,
  parameter int AW          = 8,
  parameter int ENTRY_BYTES = 5
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [31:0] now_time_lo,
  input  wire logic [31:0] now_time_hi,
  input  wire logic        record_key,
  input  wire logic        sync_in,
  input  wire logic        sample_valid,
  input  wire logic [31:0] sample_value,
  input  wire logic        sample_under,
  input  wire logic        sample_over,
  input  wire logic        sample_undef,
  input  wire logic        sample_navail,
  input  wire logic        sample_is_pf,
  input  wire logic        sample_pf_cap,
  input  wire logic        func_valid,
  input  wire logic [31:0] func_value,
  output logic             recording,
  output logic             out_valid,
  output logic      [31:0] out_data,
  output logic             out_is_status,
  output logic             out_last
);
  localparam int FREE_MAX = DEPTH * ENTRY_BYTES;

  ////////////////////////////////////////////////////////////////////
  // Configuration and command decode
  // Settings held between writes
  logic             rec_en_reg;
  logic             slope_neg_reg;
  logic             sweep_rt_reg;
  start_src_t       src_reg;
  logic [31:0]      level_reg;
  logic [31:0]      time_lo_reg;
  logic [31:0]      time_hi_reg;
  logic [AW-1:0]    rd_count_reg;
  // Strobes decoded from a command word write
  logic             cmd_wr;
  logic             bus_trg;
  logic             del_all;
  logic             read_req;

  // Command bits act as one-cycle strobes
  assign cmd_wr   = wr && (addr == `OFF_CMD);
  assign bus_trg  = cmd_wr && wdata[`CMD_BUS_TRG_BIT];
  assign del_all  = cmd_wr && wdata[`CMD_DEL_ALL_BIT];
  assign read_req = cmd_wr && wdata[`CMD_READ_BIT];

  // Writable settings
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rec_en_reg    <= 1'b0;
      slope_neg_reg <= 1'b0;
      sweep_rt_reg  <= 1'b0;
      src_reg       <= start_src_t'(`RST_SRC);
      level_reg     <= `RST_LEVEL;
      time_lo_reg   <= 32'h00000000;
      time_hi_reg   <= 32'h00000000;
      rd_count_reg  <= '0;
    end else if (wr) begin
      case (addr)
        `OFF_CTRL: begin
          rec_en_reg    <= wdata[`CTRL_REC_EN_BIT];
          slope_neg_reg <= wdata[`CTRL_SLOPE_BIT];
          sweep_rt_reg  <= wdata[`CTRL_SWEEP_BIT];
        end
        `OFF_SRC: begin
          if (wdata[2:0] <= 3'h5) begin
            src_reg <= start_src_t'(wdata[2:0]);
          end
        end
        `OFF_LEVEL:    level_reg    <= wdata;
        `OFF_TIME_LO:  time_lo_reg  <= wdata;
        `OFF_TIME_HI:  time_hi_reg  <= wdata;
        `OFF_RD_COUNT: rd_count_reg <= wdata[AW-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Start trigger
  // Edge and crossing history, time compare
  logic [63:0] now_time;
  logic [63:0] start_time;
  logic        sync_d_reg;
  logic        func_above_reg;
  logic        func_seen_reg;
  logic        func_above;
  logic        func_cross;
  logic        time_hit;
  logic        start_hit;

  // Signed float compare of averaged function against level
  function automatic logic fgt(input logic [31:0] a, input logic [31:0] b);
    logic r;
    r = 1'b0;
    if (a[31] != b[31]) begin
      r = !a[31] && (a[30:0] != 31'h0 || b[30:0] != 31'h0);
    end else if (!a[31]) begin
      r = a[30:0] > b[30:0];
    end else begin
      r = a[30:0] < b[30:0];
    end
    return r;
  endfunction

  assign func_above = fgt(func_value, level_reg);
  // Crossing in the chosen direction
  assign func_cross = func_valid && func_seen_reg &&
                      (slope_neg_reg ? (func_above_reg && !func_above)
                                     : (!func_above_reg && func_above));
  // Exact match of the whole 64-bit device time
  assign now_time   = {now_time_hi, now_time_lo};
  assign start_time = {time_hi_reg, time_lo_reg};
  assign time_hit   = (now_time == start_time);

  // Source selection
  always_comb begin
    case (src_reg)
      SRC_BUS:           start_hit = bus_trg;
      SRC_TIME:          start_hit = time_hit;
      SRC_START_AT_ONCE: start_hit = 1'b1;
      SRC_MANUAL:        start_hit = record_key;
      SRC_SYNC:          start_hit = sweep_rt_reg && sync_in && !sync_d_reg;
      SRC_FUNC:          start_hit = func_cross;
      default:           start_hit = 1'b0;
    endcase
  end

  // Sync edge history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_in;
    end
  end

  // Function history; first sample only arms the detector
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      func_above_reg <= 1'b0;
      func_seen_reg  <= 1'b0;
    end else if (func_valid) begin
      func_above_reg <= func_above;
      func_seen_reg  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Recording into memory
  logic [AW:0]   fill_reg;
  logic          mem_wr;
  logic [39:0]   mem_wdata;
  logic [7:0]    stat_in;
  logic [31:0]   val_in;
  logic          mem_full;

  assign mem_full = (fill_reg == (AW+1)'(DEPTH));
  assign mem_wr   = recording && sample_valid && !mem_full;

  // Status mask built from independent conditions
  always_comb begin
    stat_in = 8'h00;
    if (sample_under)  stat_in = stat_in | `ST_UNDER;
    if (sample_over)   stat_in = stat_in | `ST_OVER;
    if (sample_undef)  stat_in = stat_in | `ST_UNDEF;
    if (sample_navail) stat_in = stat_in | `ST_NAVAIL;
    if (sample_is_pf && sample_pf_cap) begin
      stat_in = stat_in | `ST_PF_CAP;
    end
    stat_in = stat_in & `ST_USED_MASK;
  end

  // Undefined or unavailable values become NaN
  assign val_in = (sample_undef || sample_navail) ? `NAN_WORD : sample_value;
  assign mem_wdata = {stat_in, val_in};

  // Recording state; a disabled recorder ignores every trigger
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      recording <= 1'b0;
    end else if (!rec_en_reg) begin
      recording <= 1'b0;
    end else if (start_hit && !recording) begin
      recording <= 1'b1;
    end else if (mem_full) begin
      recording <= 1'b0;
    end
  end

  // Fill level; delete-all frees every entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fill_reg <= '0;
    end else if (del_all) begin
      fill_reg <= '0;
    end else if (mem_wr) begin
      fill_reg <= fill_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Readout: all values first, then one status each
  rd_state_t     rd_state_reg;
  logic [AW:0]   rd_idx_reg;
  logic [AW:0]   rd_len_reg;
  logic          pend_reg;
  logic [39:0]   mem_rdata;
  logic [AW-1:0] mem_raddr;

  // Memory walks the entries in order
  assign mem_raddr = rd_idx_reg[AW-1:0];

  rec_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clock   (clock),
    .wr_en   (mem_wr),
    .wr_addr (fill_reg[AW-1:0]),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  // Readout sequencer; memory data lag address by one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_reg  <= RD_IDLE;
      rd_idx_reg    <= '0;
      rd_len_reg    <= '0;
      pend_reg      <= 1'b0;
      out_valid     <= 1'b0;
      out_data      <= 32'h00000000;
      out_is_status <= 1'b0;
      out_last      <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      out_last  <= 1'b0;
      case (rd_state_reg)
        RD_IDLE: begin
          // Nothing recorded: request gets no answer
          if (read_req && fill_reg != '0) begin
            rd_state_reg <= RD_DATA;
            rd_idx_reg   <= '0;
            pend_reg     <= 1'b0;
            if (rd_count_reg == '0 || {1'b0, rd_count_reg} > fill_reg) begin
              rd_len_reg <= fill_reg;
            end else begin
              rd_len_reg <= {1'b0, rd_count_reg};
            end
          end
        end
        RD_DATA, RD_STATUS: begin
          if (pend_reg) begin
            out_valid     <= 1'b1;
            out_is_status <= (rd_state_reg == RD_STATUS);
            out_data      <= (rd_state_reg == RD_STATUS) ?
                             {24'h000000, mem_rdata[39:32]} : mem_rdata[31:0];
            out_last      <= (rd_state_reg == RD_STATUS) && (rd_idx_reg == rd_len_reg);
          end
          if (rd_idx_reg == rd_len_reg) begin
            rd_idx_reg <= '0;
            pend_reg   <= 1'b0;
            if (pend_reg) begin
              rd_state_reg <= (rd_state_reg == RD_DATA) ? RD_STATUS : RD_DONE;
            end
          end else begin
            rd_idx_reg <= rd_idx_reg + 1'b1;
            pend_reg   <= 1'b1;
          end
        end
        RD_DONE: begin
          rd_state_reg <= RD_IDLE;
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read port
  logic [31:0] free_bytes;

  assign free_bytes = 32'(FREE_MAX) - 32'(fill_reg) * 32'(ENTRY_BYTES);

  // Read data one cycle after strobe; unmapped read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `OFF_CTRL:     rdata <= {29'h0, sweep_rt_reg, slope_neg_reg, rec_en_reg};
        `OFF_SRC:      rdata <= {29'h0, src_reg};
        `OFF_LEVEL:    rdata <= level_reg;
        `OFF_TIME_LO:  rdata <= time_lo_reg;
        `OFF_TIME_HI:  rdata <= time_hi_reg;
        `OFF_FREE:     rdata <= free_bytes;
        `OFF_BLOCKS:   rdata <= `BLOCK_COUNT;
        `OFF_STATE:    rdata <= {27'h0, rd_state_reg, recording};
        `OFF_RD_COUNT: rdata <= 32'(rd_count_reg);
        default:       rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule

// ==== sim/rec_trig_monitor.sv ====
`timescale 1ns/1ps
`include "rec_trig_consts.svh"
module rec_trig_monitor
  import rec_trig_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        record_key,
  input wire logic        recording,
  input wire logic        out_valid,
  input wire logic [31:0] out_data,
  input wire logic        out_is_status,
  input wire logic        out_last
);
  logic       en_q;
  logic [2:0] src_q;
  // Shadow of enable and start source
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_q  <= 1'b0;
      src_q <= `RST_SRC;
    end else if (wr && addr == `OFF_CTRL) begin
      en_q <= wdata[0];
    end else if (wr && addr == `OFF_SRC && wdata[2:0] <= 3'h5) begin
      src_q <= wdata[2:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence status_word;
    out_valid && out_is_status;
  endsequence
  sequence status_mid;
    out_valid && out_is_status && !out_last;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_unused_bits: assert property (status_word |-> out_data[31:8] == 24'h0
    && (out_data[7:0] & ~`ST_USED_MASK) == 8'h00) else $error("status spare bits set");
  chk_data_first: assert property (status_mid |=> !(out_valid && !out_is_status))
    else $error("value after status");
  chk_last_status: assert property (out_last |-> status_word)
    else $error("last flag off a status word");
  chk_block_one: assert property (rd && addr == `OFF_BLOCKS |=> rdata == `BLOCK_COUNT)
    else $error("block count not one");
  chk_unmapped_zero: assert property (rd && addr > 8'h09 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rec_enable: assert property ($rose(recording) |-> en_q)
    else $error("recording without enable");
  chk_rec_stop: assert property (wr && addr == `OFF_CTRL && !wdata[0] |-> ##[1:2] !recording)
    else $error("recording kept after disable");
  chk_bus_start: assert property (wr && addr == `OFF_CMD && wdata[0] && en_q
    && src_q == 3'h0 && !recording |-> ##[1:2] recording) else $error("bus trigger missed");
  chk_key_start: assert property (record_key && en_q && src_q == 3'h3
    && !recording |-> ##[1:2] recording) else $error("record key missed");
endmodule

// ==== sim/sample_feed.sv ====
`timescale 1ns/1ps
// Front-end model: one measured value with its conditions per call
module sample_feed (
  input  wire logic        clock,
  output logic             sample_valid,
  output logic      [31:0] sample_value,
  output logic      [5:0]  sample_flags
);
  // Quiet lines at start
  initial begin
    sample_valid = 1'b0;
    sample_value = 32'h0;
    sample_flags = 6'h0;
  end
  // Float value plus flags, held until the next call
  task automatic send(input logic [31:0] v, input logic [5:0] f);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_value <= v;
    sample_flags <= f;
  endtask
  // Release; stale lines toggle so they never pass as valid
  task automatic idle();
    @(posedge clock);
    sample_valid <= 1'b0;
    sample_value <= ~sample_value;
    sample_flags <= ~sample_flags;
  endtask
endmodule

// ==== sim/recording_readout_and_start_trigger_tb.sv ====
`timescale 1ns/1ps
`include "rec_trig_consts.svh"
module recording_readout_and_start_trigger_tb
  import rec_trig_pkg::*;
;
  localparam int DEPTH = 16;
  logic        clock, rst_n, wr, rd, record_key, sync_in, func_valid;
  logic        recording, out_valid, out_is_status, out_last, sample_valid;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, now_lo, now_hi, func_value, out_data, sample_value, got;
  logic [5:0]  sample_flags;
  logic [32:0] outq[$];
  int          n_errors, checks_done, cycles, last_at;
  logic [31:0] vals [5] = '{32'h41200000, 32'h3f800000, 32'h12345678, 32'h40000000, 32'h3f000000};
  logic [31:0] expv [5] = '{32'h41200000, 32'h3f800000, `NAN_WORD, `NAN_WORD, 32'h3f000000};
  logic [5:0]  flg [5] = '{6'h00, 6'h30, 6'h08, 6'h07, 6'h21};
  logic [7:0]  exps [5] = '{8'h00, 8'h03, 8'h08, 8'h90, 8'h01};
  int          srcs [5] = '{1, 3, 4, 5, 2};

  rec_trig #(.DEPTH(DEPTH), .AW(4)) i_dut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .now_time_lo(now_lo),
    .now_time_hi(now_hi), .record_key(record_key), .sync_in(sync_in),
    .sample_valid(sample_valid), .sample_value(sample_value),
    .sample_under(sample_flags[5]), .sample_over(sample_flags[4]),
    .sample_undef(sample_flags[3]), .sample_navail(sample_flags[2]),
    .sample_is_pf(sample_flags[1]), .sample_pf_cap(sample_flags[0]),
    .func_valid(func_valid), .func_value(func_value), .recording(recording),
    .out_valid(out_valid), .out_data(out_data), .out_is_status(out_is_status),
    .out_last(out_last));
  sample_feed i_src (.clock(clock), .sample_valid(sample_valid),
    .sample_value(sample_value), .sample_flags(sample_flags));

  // Clock
  always #5 clock = ~clock;
  // Timeout and capture of readout words
  always @(posedge clock) begin
    cycles++;
    if (out_valid === 1'b1) outq.push_back({out_is_status, out_data});
    if (out_last === 1'b1) last_at = outq.size();
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [32:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic expect_rec(input logic e);
    repeat (3) @(posedge clock);
    #1 check("recording", recording, e);
  endtask
  // Raise the event of one start source; 6 is a falling crossing
  task automatic fire(input int s);
    @(posedge clock);
    case (s)
      1: now_lo <= 32'h9;
      3: record_key <= 1'b1;
      4: sync_in <= 1'b1;
      5, 6: begin
        func_valid <= 1'b1;
        func_value <= (s == 6) ? 32'h3f800000 : 32'hbf800000;
      end
      default: ;
    endcase
    @(posedge clock);
    func_value <= (s == 6) ? 32'hbf800000 : 32'h3f800000;
    @(posedge clock);
    now_lo <= 32'h0;
    record_key <= 1'b0;
    sync_in <= 1'b0;
    func_valid <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clock, rst_n, wr, rd, record_key, sync_in, func_valid} = '0;
    {addr, wdata, now_lo, now_hi, func_value} = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(`OFF_BLOCKS, got);
    check("blocks", got, `BLOCK_COUNT);
    rd_reg(`OFF_FREE, got);
    check("free", got, 32'(DEPTH * 5));
    rd_reg(8'h3c, got);
    check("unmapped", got, 33'h0);
    rd_reg(`OFF_SRC, got);
    check("src reset", got, `RST_SRC);
    wr_reg(`OFF_CMD, 32'h4);
    expect_rec(1'b0);
    check("empty readout", 33'(outq.size()), 33'h0);
    $display("test registers done");
    wr_reg(`OFF_SRC, 32'h0);
    wr_reg(`OFF_CTRL, 32'h1);
    expect_rec(1'b0);
    wr_reg(`OFF_CMD, 32'h1);
    expect_rec(1'b1);
    for (int i = 0; i < 5; i++) i_src.send(vals[i], flg[i]);
    i_src.idle();
    wr_reg(`OFF_CTRL, 32'h0);
    rd_reg(`OFF_FREE, got);
    check("free used", got, 32'((DEPTH - 5) * 5));
    wr_reg(`OFF_RD_COUNT, 32'h0);
    wr_reg(`OFF_CMD, 32'h4);
    repeat (30) @(posedge clock);
    check("words", 33'(outq.size()), 33'd10);
    check("last", 33'(last_at), 33'd10);
    for (int i = 0; i < 5; i++) begin
      check("value", outq[i], {1'b0, expv[i]});
      check("status", outq[i + 5], {9'h100, 16'h0, exps[i]});
    end
    wr_reg(`OFF_RD_COUNT, 32'h2);
    wr_reg(`OFF_CMD, 32'h4);
    repeat (20) @(posedge clock);
    check("words n", 33'(outq.size()), 33'd14);
    check("last n", 33'(last_at), 33'd14);
    for (int i = 0; i < 2; i++) begin
      check("value n", outq[10 + i], {1'b0, expv[i]});
      check("status n", outq[12 + i], {9'h100, 16'h0, exps[i]});
    end
    wr_reg(`OFF_CMD, 32'h2);
    rd_reg(`OFF_FREE, got);
    check("free deleted", got, 32'(DEPTH * 5));
    $display("test readout done");
    wr_reg(`OFF_TIME_LO, 32'h9);
    for (int k = 0; k < 5; k++) begin
      wr_reg(`OFF_CTRL, 32'h0);
      wr_reg(`OFF_SRC, 32'(srcs[k]));
      wr_reg(`OFF_CTRL, 32'h5);
      if (srcs[k] != 2) expect_rec(1'b0);
      fire(srcs[k]);
      expect_rec(1'b1);
    end
    wr_reg(`OFF_CTRL, 32'h0);
    wr_reg(`OFF_SRC, 32'h1);
    wr_reg(`OFF_TIME_HI, 32'h1);
    wr_reg(`OFF_CTRL, 32'h1);
    fire(1);
    expect_rec(1'b0);
    @(posedge clock);
    now_hi <= 32'h1;
    fire(1);
    expect_rec(1'b1);
    wr_reg(`OFF_CTRL, 32'h0);
    wr_reg(`OFF_SRC, 32'h4);
    wr_reg(`OFF_CTRL, 32'h1);
    fire(4);
    expect_rec(1'b0);
    wr_reg(`OFF_CTRL, 32'h0);
    wr_reg(`OFF_SRC, 32'h5);
    wr_reg(`OFF_CTRL, 32'h3);
    rd_reg(`OFF_CTRL, got);
    check("ctrl", got, 33'h3);
    fire(6);
    expect_rec(1'b1);
    wr_reg(`OFF_CTRL, 32'h0);
    wr_reg(`OFF_CTRL, 32'h3);
    fire(5);
    expect_rec(1'b0);
    $display("test sources done");
    complete_run();
  end
endmodule

bind rec_trig rec_trig_monitor i_mon (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .record_key(record_key),
  .recording(recording), .out_valid(out_valid), .out_data(out_data),
  .out_is_status(out_is_status), .out_last(out_last));
